// ==== design/otgef_event_flags.sv ====
// Event-flag register of an OTG port: sticky flags, write one to clear.
// Assumes command strobes and event pulses are synchronous to i_sys_clk;
// the bus pins i_dp, i_dm and i_vbus_valid are asynchronous and synchronised here.
`default_nettype none

// Operation
// - Read flags with command 68h, write them with E8h; same contents.
// - Writing one clears a flag; writing zero leaves it unchanged.
// - Timer-expired flag, bit 10, sets on OTG timer time-out, sticky.
// - Long-SE0 flag, bit 9, sets after more than 2 ms of SE0.
// - Session-request flag, bit 8, sets on VBUS or data-line pulsing.
// - Session request type chosen by control register bit 9 select.
// - Resume flag, bit 7, sets on J-to-K change while suspended.
// - Suspend flag, bit 6, sets when bus idle exceeds 3 ms.
module otgef_event_flags #(
    parameter int LONG_SE0_CYCLES = otgef_pkg::LONG_SE0_CYCLES,
    parameter int SUSPEND_CYCLES  = otgef_pkg::SUSPEND_CYCLES
) (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    // Command port
    input  wire logic        i_cmd_valid,
    input  wire logic [7:0]  i_cmd_code,
    input  wire logic [15:0] i_wr_data,
    output logic      [15:0] o_rd_data,
    output logic             o_rd_valid,
    // Event sources on the system clock
    input  wire logic        i_otg_timer_timeout,
    input  wire logic [5:0]  i_change_events,
    input  wire logic        i_session_request_type_select,
    // Bus pins, asynchronous
    input  wire logic        i_dp,
    input  wire logic        i_dm,
    input  wire logic        i_vbus_valid,
    // Flag state
    output logic      [15:0] o_event_flags,
    output logic             o_port_suspended
);

    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    generate
        if (LONG_SE0_CYCLES < 1 || SUSPEND_CYCLES < 1) begin : g_bad_time
            $error("otgef_event_flags: hold counts must be at least 1");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    localparam int NPIN = 3;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;

    assign pin_raw = {i_vbus_valid, i_dm, i_dp};

    // Two flops per pin; only the second stage is used by logic
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge i_sys_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    logic dp_s;
    logic dm_s;
    logic vbus_s;
    assign dp_s   = sync2_q[0];
    assign dm_s   = sync2_q[1];
    assign vbus_s = sync2_q[2];

    // ---------------------------------------------------------------
    // Line state decode
    // ---------------------------------------------------------------
    // Full-speed polarity: J has D+ high, K has D- high
    logic line_se0;
    logic line_j;
    logic line_k;
    assign line_se0 = !dp_s && !dm_s;
    assign line_j   = dp_s && !dm_s;
    assign line_k   = !dp_s && dm_s;

    // ---------------------------------------------------------------
    // Duration timers
    // ---------------------------------------------------------------
    logic se0_expired;
    logic idle_expired;
    logic idle_held;

    otgef_hold_timer #(
        .HOLD_CYCLES (LONG_SE0_CYCLES)
    ) u_se0_timer (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_level   (line_se0),
        .o_expired (se0_expired),
        .o_held    ()
    );

    otgef_hold_timer #(
        .HOLD_CYCLES (SUSPEND_CYCLES)
    ) u_idle_timer (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_level   (line_j),
        .o_expired (idle_expired),
        .o_held    (idle_held)
    );

    // ---------------------------------------------------------------
    // Line history
    // ---------------------------------------------------------------
    logic prev_j_q;
    logic prev_j_d;
    logic prev_dp_q;
    logic prev_dp_d;
    logic prev_vbus_q;
    logic prev_vbus_d;
    logic suspended_q;
    logic suspended_d;
    logic [1:0] warm_q;
    logic [1:0] warm_d;
    logic       hist_ok;

    // Edges are only trusted once synchronisers and history hold real pin
    // values; otherwise a pin already high at reset release looks like a pulse
    localparam logic [1:0] WARM_DONE = 2'(otgef_pkg::SYNC_STAGES + 1);

    // Suspend state is kept from the previous cycle; the idle timer's held
    // output only drops the cycle after the K state arrives
    always_comb begin
        prev_j_d    = line_j;
        prev_dp_d   = dp_s;
        prev_vbus_d = vbus_s;
        suspended_d = idle_held || idle_expired;
        warm_d      = (warm_q == WARM_DONE) ? warm_q : warm_q + 2'h1;
    end

    assign hist_ok = (warm_q == WARM_DONE);

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_j_q    <= 1'b0;
            prev_dp_q   <= 1'b0;
            prev_vbus_q <= 1'b0;
            suspended_q <= 1'b0;
            warm_q      <= 2'h0;
        end else begin
            prev_j_q    <= prev_j_d;
            prev_dp_q   <= prev_dp_d;
            prev_vbus_q <= prev_vbus_d;
            suspended_q <= suspended_d;
            warm_q      <= warm_d;
        end
    end

    // ---------------------------------------------------------------
    // Event detection
    // ---------------------------------------------------------------
    logic srp_event;
    logic resume_event;

    // A pulse is seen by its rising edge; the select picks the source
    always_comb begin
        if (i_session_request_type_select == otgef_pkg::SRP_TYPE_VBUS) begin
            srp_event = hist_ok && vbus_s && !prev_vbus_q;
        end else begin
            srp_event = hist_ok && dp_s && !prev_dp_q;
        end
    end

    assign resume_event = suspended_q && prev_j_q && line_k;

    // ---------------------------------------------------------------
    // Command decode
    // ---------------------------------------------------------------
    function automatic logic cmd_is(input logic valid,
                                    input logic [7:0] code,
                                    input logic [7:0] want);
        cmd_is = valid && (code == want);
    endfunction

    logic rd_cmd;
    logic wr_cmd;
    assign rd_cmd = cmd_is(i_cmd_valid, i_cmd_code, otgef_pkg::CMD_READ_FLAGS);
    assign wr_cmd = cmd_is(i_cmd_valid, i_cmd_code, otgef_pkg::CMD_WRITE_FLAGS);

    // ---------------------------------------------------------------
    // Flag register
    // ---------------------------------------------------------------
    logic [15:0] flags_q;
    logic [15:0] flags_d;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] rd_data_q;
    logic [15:0] rd_data_d;
    logic        rd_valid_q;
    logic        rd_valid_d;

    // Set beats clear so an event landing on a clear write is kept
    always_comb begin
        set_vec = 16'h0000;
        set_vec[otgef_pkg::BIT_TIMER_EXPIRED] = i_otg_timer_timeout;
        set_vec[otgef_pkg::BIT_LONG_SE0]      = se0_expired;
        set_vec[otgef_pkg::BIT_SESSION_REQ]   = srp_event;
        set_vec[otgef_pkg::BIT_RESUME_DETECT] = resume_event;
        set_vec[otgef_pkg::BIT_PORT_SUSPEND]  = idle_expired;
        set_vec[otgef_pkg::CHANGE_FLAG_COUNT-1:0] = i_change_events;
        clr_vec = wr_cmd ? i_wr_data : 16'h0000;
        flags_d = ((flags_q & ~clr_vec) | set_vec)
                  & otgef_pkg::FLAGS_DEFINED_MASK;
        rd_valid_d = rd_cmd;
        rd_data_d  = rd_cmd ? (flags_q & otgef_pkg::FLAGS_DEFINED_MASK)
                            : rd_data_q;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_q    <= otgef_pkg::FLAGS_RESET;
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else begin
            flags_q    <= flags_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs, all straight from flops
    // ---------------------------------------------------------------
    assign o_rd_data        = rd_data_q;
    assign o_rd_valid       = rd_valid_q;
    assign o_event_flags    = flags_q;
    assign o_port_suspended = suspended_q;

endmodule

`default_nettype wire

// ==== design/otgef_pkg.sv ====
// Constants shared by the OTG event-flag register and its hold timer.
// Assumes a 25 MHz system clock; all times are turned into cycle counts here.
`default_nettype none

package otgef_pkg;

    // ---------------------------------------------------------------
    // Command codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_READ_FLAGS  = 8'h68;
    localparam logic [7:0] CMD_WRITE_FLAGS = 8'hE8;

    // ---------------------------------------------------------------
    // Register layout
    // ---------------------------------------------------------------
    localparam int          REG_WIDTH          = 16;
    localparam int          BIT_TIMER_EXPIRED  = 10;
    localparam int          BIT_LONG_SE0       = 9;
    localparam int          BIT_SESSION_REQ    = 8;
    localparam int          BIT_RESUME_DETECT  = 7;
    localparam int          BIT_PORT_SUSPEND   = 6;
    localparam int          CHANGE_FLAG_COUNT  = 6;
    localparam logic [15:0] FLAGS_RESET        = 16'h0000;
    localparam logic [15:0] FLAGS_DEFINED_MASK = 16'h07FF;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_FREQ_KHZ      = 25000;
    localparam int LONG_SE0_TIME_US  = 2000;
    localparam int SUSPEND_TIME_US   = 3000;
    // Longest-time limits: "more than" a time means strictly past these counts
    localparam int LONG_SE0_CYCLES   = LONG_SE0_TIME_US * CLK_FREQ_KHZ / 1000;
    localparam int SUSPEND_CYCLES    = SUSPEND_TIME_US * CLK_FREQ_KHZ / 1000;

    // Session request type select encodings
    localparam logic SRP_TYPE_DATA_LINE = 1'b0;
    localparam logic SRP_TYPE_VBUS      = 1'b1;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;

endpackage

`default_nettype wire

// ==== design/otgef_hold_timer.sv ====
// Hold timer: reports when a level has stayed high for more than a set count.
// Assumes its level input is already synchronous to i_sys_clk.
`default_nettype none

module otgef_hold_timer #(
    parameter int HOLD_CYCLES = 50000
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rstn,
    // Monitored level
    input  wire logic i_level,
    // Results
    output logic      o_expired,
    output logic      o_held
);

    localparam int CW = $clog2(HOLD_CYCLES + 2);

    // ---------------------------------------------------------------
    // Elaboration check
    // ---------------------------------------------------------------
    generate
        if (HOLD_CYCLES < 1) begin : g_bad_hold
            $error("otgef_hold_timer: HOLD_CYCLES must be at least 1");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    localparam logic [CW-1:0] LIMIT = CW'(HOLD_CYCLES);

    // Saturates one past the limit so a long level fires only once
    always_comb begin
        if (!i_level) begin
            cnt_d = '0;
        end else if (cnt_q <= LIMIT) begin
            cnt_d = cnt_q + CW'(1);
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Pulse in the cycle the level passes the limit; held afterwards
    assign o_expired = i_level && (cnt_q == LIMIT);
    assign o_held    = (cnt_q > LIMIT);

endmodule

`default_nettype wire

// ==== testbench/otgef_event_flags_monitor.sv ====
// Checker for the OTG event-flag register, bound to its ports.
// Assumes raw bus pins; sync lag is covered by two cycles of slack.
`default_nettype none

module otgef_event_flags_monitor #(
    parameter int LONG_SE0_CYCLES = 50000,
    parameter int SUSPEND_CYCLES  = 75000
) (
    // Clock, reset and commands
    input wire logic        i_sys_clk,
    input wire logic        i_rstn,
    input wire logic        i_cmd_valid,
    input wire logic [7:0]  i_cmd_code,
    input wire logic [15:0] i_wr_data,
    input wire logic [15:0] o_rd_data,
    input wire logic        o_rd_valid,
    // Events and pins
    input wire logic        i_otg_timer_timeout,
    input wire logic [5:0]  i_change_events,
    input wire logic        i_session_request_type_select,
    input wire logic        i_dp,
    input wire logic        i_dm,
    input wire logic        i_vbus_valid,
    input wire logic [15:0] o_event_flags,
    input wire logic        o_port_suspended
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Helper run-length counters of the raw line state
    // ------------------------------------------------------------
    int   se0_q;
    int   j_q;
    logic clr10;
    assign clr10 = i_cmd_valid && i_cmd_code == 8'hE8 && i_wr_data[10];
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            se0_q <= 0;
            j_q   <= 0;
        end else begin
            se0_q <= (!i_dp && !i_dm) ? se0_q + 1 : 0;
            j_q   <= (i_dp && !i_dm) ? j_q + 1 : 0;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    sequence rd_cmd_s;
        i_cmd_valid && i_cmd_code == 8'h68;
    endsequence
    rd_answer_a: assert property (rd_cmd_s
        |=> o_rd_valid && o_rd_data == $past(o_event_flags))
        else $error("read answer wrong");
    rd_quiet_a: assert property (!(i_cmd_valid && i_cmd_code == 8'h68) |=> !o_rd_valid)
        else $error("read valid without read");
    rsvd_zero_a: assert property (o_event_flags[15:11] == 5'h00)
        else $error("reserved bits set");
    timer_set_a: assert property (i_otg_timer_timeout |=> o_event_flags[10])
        else $error("timer flag not set");
    timer_clear_a: assert property (clr10 && !i_otg_timer_timeout |=> !o_event_flags[10])
        else $error("timer flag not cleared");
    timer_hold_a: assert property (o_event_flags[10] && !clr10 |=> o_event_flags[10])
        else $error("timer flag lost");
    se0_long_a: assert property ($rose(o_event_flags[9])
        |-> $past(se0_q, 3) >= LONG_SE0_CYCLES - 2)
        else $error("SE0 flag too early");
    suspend_entry_a: assert property ($rose(o_port_suspended)
        |-> ($past(j_q, 3) >= SUSPEND_CYCLES - 2) ##[0:1] o_event_flags[6])
        else $error("suspend wrong");
    resume_detect_a: assert property ($rose(o_event_flags[7]) |-> $past(o_port_suspended))
        else $error("resume outside suspend");
endmodule

bind otgef_event_flags otgef_event_flags_monitor #(
    .LONG_SE0_CYCLES(LONG_SE0_CYCLES),
    .SUSPEND_CYCLES (SUSPEND_CYCLES)
) i_mon (.i_sys_clk, .i_rstn, .i_cmd_valid, .i_cmd_code, .i_wr_data, .o_rd_data,
    .o_rd_valid, .i_otg_timer_timeout, .i_change_events, .i_session_request_type_select,
    .i_dp, .i_dm, .i_vbus_valid, .o_event_flags, .o_port_suspended);

`default_nettype wire

// ==== testbench/otgef_event_flags_tb.sv ====
// Self-checking bench for the OTG event-flag register.
// Assumes short SE0 and suspend counts set below.
`default_nettype none

module otgef_event_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SE0_N = 20;
    localparam int SUS_N = 30;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        vld = 1'b0;
    logic [7:0]  code = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        tmo = 1'b0;
    logic [5:0]  chg = 6'h00;
    logic        sel = 1'b1;
    logic        dp = 1'b1;
    logic        dm = 1'b1;
    logic        vbus = 1'b0;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [15:0] flags;
    logic        susp;
    logic [15:0] exp = 16'h0000;
    logic [15:0] r = 16'h005A;
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles = 0;

    otgef_event_flags #(.LONG_SE0_CYCLES(SE0_N), .SUSPEND_CYCLES(SUS_N)) i_dut (
        .i_sys_clk(clk), .i_rstn(rstn), .i_cmd_valid(vld), .i_cmd_code(code),
        .i_wr_data(wdata), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .i_otg_timer_timeout(tmo), .i_change_events(chg),
        .i_session_request_type_select(sel), .i_dp(dp), .i_dm(dm),
        .i_vbus_valid(vbus), .o_event_flags(flags), .o_port_suspended(susp));

    // Clock and a cycle ceiling so a hang still reaches the verdict
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            report_and_stop();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        tests_run++;
        if (got !== want) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One command: a single-cycle strobe
    task automatic cmd(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        vld   <= 1'b1;
        code  <= c;
        wdata <= d;
        @(posedge clk);
        vld <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] d);
        cmd(8'hE8, d);
        exp = exp & ~d;
    endtask
    task automatic rd();
        cmd(8'h68, 16'h0000);
        #1;
        chk({15'h0000, rd_valid}, 16'h0001);
        chk(rd_data, exp);
        chk(flags, exp);
    endtask
    task automatic line(input logic p, input logic m, input int n);
        @(posedge clk);
        dp <= p;
        dm <= m;
        wt(n);
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        wt(10);
        rstn <= 1'b1;
        chk(flags, 16'h0000);
        rd();
        // Random events then random write-one clears, reserved bits included
        for (int k = 0; k < 40; k++) begin
            r = lfsr(r);
            @(posedge clk);
            tmo <= r[10];
            chg <= r[5:0];
            @(posedge clk);
            tmo <= 1'b0;
            chg <= 6'h00;
            exp = exp | (r & 16'h043F);
            r = lfsr(r);
            wr(r);
            rd();
        end
        // Reset in mid-run must clear every flag
        @(posedge clk);
        rstn <= 1'b0;
        wt(2);
        rstn <= 1'b1;
        exp = 16'h0000;
        rd();
        // Unknown codes sent while every flag is clear; the next read must still see none
        cmd(8'h67, 16'hFFFF);
        cmd(8'hE9, 16'hFFFF);
        rd();
        wr(16'hFFFF);
        // SE0 just short of the limit, then well past it
        line(1'b0, 1'b0, SE0_N - 4);
        line(1'b1, 1'b1, 8);
        rd();
        line(1'b0, 1'b0, SE0_N + 6);
        line(1'b1, 1'b1, 8);
        exp[9] = 1'b1;
        rd();
        wr(16'hFFFF);
        // J to K without suspend, then with it
        line(1'b1, 1'b0, 5);
        chk({15'h0000, susp}, 16'h0000);
        line(1'b0, 1'b1, 8);
        line(1'b1, 1'b1, 8);
        rd();
        line(1'b1, 1'b0, SUS_N + 6);
        chk({15'h0000, susp}, 16'h0001);
        line(1'b0, 1'b1, 8);
        exp = exp | 16'h00C0;
        rd();
        line(1'b1, 1'b1, 8);
        wr(16'h00C0);
        rd();
        // Session request: only the selected pin counts
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 2; p++) begin
                @(posedge clk);
                sel <= s[0];
                if (p == 1) begin
                    @(posedge clk);
                    vbus <= 1'b1;
                    wt(6);
                    vbus <= 1'b0;
                    wt(6);
                end else begin
                    line(1'b0, 1'b1, 6);
                    line(1'b1, 1'b1, 6);
                end
                exp[8] = (s == p);
                rd();
                wr(16'h0100);
            end
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
